//--- hdl/gasr_pkg.sv
// Package for the gauge alarm and statistics register bank.
// Assumes a 16-bit word register port with an 8-bit command address.
package gasr_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CYCLE      = 8'h17;
  localparam logic [7:0] OFS_STATE      = 8'h19;
  localparam logic [7:0] OFS_PROFILE    = 8'h1a;
  localparam logic [7:0] OFS_TERM_RATE  = 8'h1c;
  localparam logic [7:0] OFS_EMPTY_V    = 8'h1d;
  localparam logic [7:0] OFS_EMPTY_OFS  = 8'h1e;
  localparam logic [7:0] OFS_HI_V       = 8'h1f;
  localparam logic [7:0] OFS_LO_T       = 8'h20;
  localparam logic [7:0] OFS_HI_T       = 8'h21;
  localparam logic [7:0] OFS_RUN_LO     = 8'h24;
  localparam logic [7:0] OFS_RUN_HI     = 8'h25;
  localparam logic [7:0] OFS_TACC_LO    = 8'h26;
  localparam logic [7:0] OFS_TACC_HI    = 8'h27;
  localparam logic [7:0] OFS_CACC_LO    = 8'h28;
  localparam logic [7:0] OFS_CACC_HI    = 8'h29;
  localparam logic [7:0] OFS_PEAK_V     = 8'h2a;
  localparam logic [7:0] OFS_LOW_V      = 8'h2b;
  localparam logic [7:0] OFS_PEAK_T     = 8'h2c;
  localparam logic [7:0] OFS_LOW_T      = 8'h2d;
  localparam logic [7:0] OFS_AMBIENT    = 8'h30;
  localparam logic [7:0] OFS_HEALTH     = 8'h32;
  localparam logic [7:0] OFS_USER_LO    = 8'h36;
  localparam logic [7:0] OFS_USER_HI    = 8'h37;
  // Pack state word bit positions
  localparam int BIT_HI_V     = 15;
  localparam int BIT_HI_T     = 12;
  localparam int BIT_LO_V     = 11;
  localparam int BIT_LO_CHG   = 9;
  localparam int BIT_LO_T     = 8;
  localparam int BIT_INIT     = 7;
  localparam int BIT_DISCH    = 6;
  // Writable alarm bits (hardware sets, host clears)
  localparam logic [15:0] ALARM_MASK    = 16'h9b00;
  localparam logic [15:0] STATE_RESET   = 16'h00c0;
  // Reset values, full codes, limits and cycle step
  localparam logic [15:0] TERM_RESET    = 16'h0002;
  localparam logic [15:0] HEALTH_RESET  = 16'h0064;
  localparam logic [15:0] LEVEL_FULL    = 16'h03e8;
  localparam logic [15:0] PCT_FULL      = 16'h0064;
  localparam logic [15:0] LOW_V_RESET   = 16'hffff;
  localparam logic [15:0] COLD_LIMIT    = 16'h0aac;
  localparam logic [15:0] AMB_MIN       = 16'h0980;
  localparam logic [15:0] AMB_MAX       = 16'h0dcc;
  localparam logic [15:0] CYCLE_STEP    = 16'h0064;
  // Saturation limits
  localparam logic [31:0] RUN_MAX       = 32'h00ffffff;
  localparam logic [31:0] TACC_MAX      = 32'h0fffffff;
  localparam logic [31:0] CACC_MAX      = 32'hffffffff;
  // Power modes
  localparam logic [7:0]  MODE_OPER     = 8'h01;
  localparam logic [7:0]  MODE_SLEEP    = 8'h02;

  // Measurement sample from the front end
  typedef struct packed {
    logic        valid;
    logic [15:0] cell_mv;
    logic [15:0] cell_temp;
    logic [15:0] amb_temp;
    logic [15:0] fine_level;
    logic        discharging;
    logic [6:0]  health;
  } gasr_meas_t;

  // Register write/read command
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } gasr_cmd_t;

  // All state of the bank
  typedef struct packed {
    logic [15:0] cycle;
    logic [15:0] drop_acc;
    logic [15:0] last_pct;
    logic [15:0] state;
    logic [15:0] term_rate;
    logic [15:0] empty_v;
    logic [15:0] empty_ofs;
    logic [15:0] hi_v;
    logic [15:0] lo_t;
    logic [15:0] hi_t;
    logic [15:0] lo_chg;
    logic [15:0] lo_v;
    logic [31:0] run;
    logic [31:0] tacc;
    logic [31:0] cacc;
    logic [15:0] peak_v;
    logic [15:0] low_v;
    logic [15:0] peak_t;
    logic [15:0] low_t;
    logic [15:0] ambient;
    logic [15:0] health;
    logic [15:0] pct;
    logic [15:0] rdata;
    logic        alarm_n;
  } gasr_state_t;
endpackage

//--- hdl/gasr_regs.sv
// Alarm, status and lifetime statistics register bank of a one-cell gauge.
// Assumes a register port decoded by a serial slave on ref_clk, measurement
// samples from the front end on ref_clk, and a one-cycle minute tick.
// How it works
// [R01] Cycle total adds one per 100 percent of summed charge-percentage drop.
// [R02] Alarm bits latch when set and hold until the host writes zero.
// [R03] State bit 6 shows discharging (1) or charging (0); resets to 1.
// [R04] State bit 7 is set at reset; host clears it to spot later resets.
// [R05] Termination rate is in 0.01C and sets where percentage hits full.
// [R06] Fine level tops out at its full code at the profile end point.
// [R07] Rate 2 makes both reach full together; larger gives a full offset.
// [R08] Fine level copied to empty offset when low volt, above offset, warm.
// [R09] Empty voltage zero stops auto offset update; host writes always work.
// [R10] Percentage reads zero when fine level equals the empty offset.
// [R11] Voltage above high threshold asserts alarm, sets bit 15; zero disables.
// [R12] Temperature below low threshold asserts alarm, sets bit 8; gated.
// [R13] Temperature above high threshold asserts alarm, sets bit 12; gated.
// [R14] Active minutes count in operation only, saturate, resume from writes.
// [R15] Temperature accumulator adds per minute in operation, saturates.
// [R16] Charge accumulator adds percentage per minute in operation, saturates.
// [R17] Peak voltage follows higher samples; lower host write re-arms it.
// [R18] Lowest voltage follows lower samples; higher host write re-arms it.
// [R19] Peak temperature follows higher samples; host write re-arms it.
// [R20] Lowest temperature follows lower samples; host write re-arms it.
// [R21] Ambient reading loaded when its thermistor is enabled, clamped range.
// [R22] Health reads in percent, starts at 100, falls with wear.
// [R23] Low-charge alarm bit 9 never sets: its threshold resets to zero, has no write path, and zero disables.
// [R24] Sleep releases the alarm and freezes gauging; registers stay open.
// [R25] Alarm output follows live enabled conditions, not the latched bits.
`timescale 1ns/10ps
`default_nettype none
module gasr_regs #(
  parameter logic [15:0] PROFILE_ID = 16'h0001, // Any nonzero identity value
  parameter logic [31:0] USER_WORD  = 32'h00000000
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire gasr_pkg::gasr_cmd_t  cmd,
  output logic [15:0]             rdata,
  input  wire gasr_pkg::gasr_meas_t meas,
  input  wire logic               minute_tick,
  input  wire logic [7:0]         power_mode,
  input  wire logic               cell_therm_en,
  input  wire logic               amb_therm_en,
  output logic [15:0]             relative_charge_pct,
  output logic                    alarm_out_n
);
  gasr_pkg::gasr_state_t st_reg;
  gasr_pkg::gasr_state_t st_next;

  initial begin
    if (PROFILE_ID == 16'h0000) $error("PROFILE_ID must be nonzero");
  end

  // Saturating 32-bit add
  function automatic logic [31:0] sat_add(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic [31:0] lim);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (a >= lim || s >= {1'b0, lim}) sat_add = lim;
    else sat_add = s[31:0];
  endfunction

  // Full-side offset: each 0.01C above 0.02C lowers the full point by 1.0%
  function automatic logic [15:0] full_point(input logic [15:0] rate);
    logic [15:0] cut;
    cut = (rate > gasr_pkg::TERM_RESET) ? 16'((rate - gasr_pkg::TERM_RESET) * 16'd10)
                                        : 16'h0000;
    if (cut > 16'h00c8) cut = 16'h00c8;
    full_point = gasr_pkg::LEVEL_FULL - cut;
  endfunction

  logic oper;
  logic c_hi_v, c_lo_t, c_hi_t, c_lo_chg, c_lo_v;
  logic [15:0] fullp;
  logic [31:0] span;
  logic [31:0] num;

  assign oper = (power_mode == gasr_pkg::MODE_OPER);
  assign fullp = full_point(st_reg.term_rate); // R05 R07

  // Live alarm conditions
  assign c_hi_v   = (st_reg.hi_v != 16'h0000) && (meas.cell_mv > st_reg.hi_v); // R11
  assign c_lo_v   = (st_reg.lo_v != 16'h0000) && (meas.cell_mv < st_reg.lo_v);
  assign c_lo_t   = cell_therm_en && (st_reg.lo_t != 16'h0000)
                    && (meas.cell_temp < st_reg.lo_t); // R12
  assign c_hi_t   = cell_therm_en && (st_reg.hi_t != 16'h0000)
                    && (meas.cell_temp > st_reg.hi_t); // R13
  assign c_lo_chg = (st_reg.lo_chg != 16'h0000) && (st_reg.pct < st_reg.lo_chg); // R23

  // Rescaling arithmetic between empty offset and full point
  assign span = (fullp > st_reg.empty_ofs) ? 32'(fullp - st_reg.empty_ofs) : 32'd1;
  assign num  = (meas.fine_level > st_reg.empty_ofs)
                ? 32'(meas.fine_level - st_reg.empty_ofs) * 32'd100 : 32'd0;

  // Next-state logic
  always_comb begin
    logic [31:0] q;
    logic [15:0] newpct;
    logic [15:0] drop;
    logic [15:0] alarms;
    q = num / span;
    st_next = st_reg;
    newpct = (q > 32'd100) ? gasr_pkg::PCT_FULL : q[15:0]; // R06 R10
    drop = 16'h0000;
    alarms = 16'h0000;

    // Measurement processing while operating
    if (oper && meas.valid) begin // R24
      st_next.pct = newpct;
      if (newpct < st_reg.last_pct) drop = st_reg.last_pct - newpct;
      st_next.last_pct = newpct;
      if (16'(st_reg.drop_acc + drop) >= gasr_pkg::CYCLE_STEP) begin // R01
        st_next.drop_acc = 16'(st_reg.drop_acc + drop - gasr_pkg::CYCLE_STEP);
        if (st_reg.cycle != 16'hffff) st_next.cycle = st_reg.cycle + 16'h0001;
      end else begin
        st_next.drop_acc = 16'(st_reg.drop_acc + drop);
      end
      st_next.state[gasr_pkg::BIT_DISCH] = meas.discharging; // R03
      if (meas.cell_mv > st_reg.peak_v) st_next.peak_v = meas.cell_mv; // R17
      if (meas.cell_mv < st_reg.low_v) st_next.low_v = meas.cell_mv; // R18
      if (cell_therm_en && meas.cell_temp > st_reg.peak_t) begin
        st_next.peak_t = meas.cell_temp; // R19
      end
      if (cell_therm_en && meas.cell_temp < st_reg.low_t) begin
        st_next.low_t = meas.cell_temp; // R20
      end
      if (amb_therm_en) begin // R21
        if (meas.amb_temp < gasr_pkg::AMB_MIN) st_next.ambient = gasr_pkg::AMB_MIN;
        else if (meas.amb_temp > gasr_pkg::AMB_MAX) st_next.ambient = gasr_pkg::AMB_MAX;
        else st_next.ambient = meas.amb_temp;
      end
      st_next.health = {9'h000, meas.health}; // R22
      // Automatic empty offset capture
      if (st_reg.empty_v != 16'h0000 && meas.cell_mv < st_reg.empty_v
          && meas.fine_level > st_reg.empty_ofs
          && meas.cell_temp > gasr_pkg::COLD_LIMIT) begin // R08 R09
        st_next.empty_ofs = meas.fine_level;
      end
    end

    // Per-minute statistics
    if (oper && minute_tick) begin
      st_next.run  = sat_add(st_reg.run, 32'd1, gasr_pkg::RUN_MAX); // R14
      st_next.tacc = sat_add(st_reg.tacc, {16'h0000, meas.cell_temp},
                             gasr_pkg::TACC_MAX); // R15
      st_next.cacc = sat_add(st_reg.cacc, {16'h0000, st_reg.pct},
                             gasr_pkg::CACC_MAX); // R16
    end

    // Host writes; they override tracking in the same cycle
    if (cmd.wr) begin
      unique case (cmd.addr)
        gasr_pkg::OFS_STATE: begin
          st_next.state = (st_reg.state & ~(gasr_pkg::ALARM_MASK
                          | (16'h0001 << gasr_pkg::BIT_INIT)))
                          | (cmd.wdata & (gasr_pkg::ALARM_MASK
                          | (16'h0001 << gasr_pkg::BIT_INIT))); // R02 R04
        end
        gasr_pkg::OFS_TERM_RATE: st_next.term_rate = cmd.wdata;
        gasr_pkg::OFS_EMPTY_V:   st_next.empty_v   = cmd.wdata;
        gasr_pkg::OFS_EMPTY_OFS: st_next.empty_ofs = cmd.wdata; // R09
        gasr_pkg::OFS_HI_V:      st_next.hi_v      = cmd.wdata;
        gasr_pkg::OFS_LO_T:      st_next.lo_t      = cmd.wdata;
        gasr_pkg::OFS_HI_T:      st_next.hi_t      = cmd.wdata;
        gasr_pkg::OFS_RUN_LO:    st_next.run[15:0]  = cmd.wdata; // R14
        gasr_pkg::OFS_RUN_HI:    st_next.run[31:16] = {8'h00, cmd.wdata[7:0]};
        gasr_pkg::OFS_TACC_LO:   st_next.tacc[15:0]  = cmd.wdata; // R15
        gasr_pkg::OFS_TACC_HI:   st_next.tacc[31:16] = {4'h0, cmd.wdata[11:0]};
        gasr_pkg::OFS_CACC_LO:   st_next.cacc[15:0]  = cmd.wdata; // R16
        gasr_pkg::OFS_CACC_HI:   st_next.cacc[31:16] = cmd.wdata;
        gasr_pkg::OFS_PEAK_V:    st_next.peak_v = cmd.wdata; // R17
        gasr_pkg::OFS_LOW_V:     st_next.low_v  = cmd.wdata; // R18
        gasr_pkg::OFS_PEAK_T:    st_next.peak_t = cmd.wdata; // R19
        gasr_pkg::OFS_LOW_T:     st_next.low_t  = cmd.wdata; // R20
        default: ;
      endcase
    end

    // Latch alarm bits; a set in the same cycle beats a host clear
    if (oper) begin
      alarms[gasr_pkg::BIT_HI_V]   = c_hi_v;
      alarms[gasr_pkg::BIT_HI_T]   = c_hi_t;
      alarms[gasr_pkg::BIT_LO_V]   = c_lo_v;
      alarms[gasr_pkg::BIT_LO_CHG] = c_lo_chg;
      alarms[gasr_pkg::BIT_LO_T]   = c_lo_t;
    end
    st_next.state = st_next.state | alarms; // R02 R11 R12 R13 R23

    // Pin follows live conditions only, released in sleep
    st_next.alarm_n = ~(oper && (c_hi_v | c_hi_t | c_lo_v | c_lo_chg | c_lo_t)); // R24 R25

    // Read data register
    st_next.rdata = st_reg.rdata;
    if (cmd.rd) begin
      unique case (cmd.addr)
        gasr_pkg::OFS_CYCLE:     st_next.rdata = st_reg.cycle;
        gasr_pkg::OFS_STATE:     st_next.rdata = st_reg.state;
        gasr_pkg::OFS_PROFILE:   st_next.rdata = PROFILE_ID;
        gasr_pkg::OFS_TERM_RATE: st_next.rdata = st_reg.term_rate;
        gasr_pkg::OFS_EMPTY_V:   st_next.rdata = st_reg.empty_v;
        gasr_pkg::OFS_EMPTY_OFS: st_next.rdata = st_reg.empty_ofs;
        gasr_pkg::OFS_HI_V:      st_next.rdata = st_reg.hi_v;
        gasr_pkg::OFS_LO_T:      st_next.rdata = st_reg.lo_t;
        gasr_pkg::OFS_HI_T:      st_next.rdata = st_reg.hi_t;
        gasr_pkg::OFS_RUN_LO:    st_next.rdata = st_reg.run[15:0];
        gasr_pkg::OFS_RUN_HI:    st_next.rdata = st_reg.run[31:16];
        gasr_pkg::OFS_TACC_LO:   st_next.rdata = st_reg.tacc[15:0];
        gasr_pkg::OFS_TACC_HI:   st_next.rdata = st_reg.tacc[31:16];
        gasr_pkg::OFS_CACC_LO:   st_next.rdata = st_reg.cacc[15:0];
        gasr_pkg::OFS_CACC_HI:   st_next.rdata = st_reg.cacc[31:16];
        gasr_pkg::OFS_PEAK_V:    st_next.rdata = st_reg.peak_v;
        gasr_pkg::OFS_LOW_V:     st_next.rdata = st_reg.low_v;
        gasr_pkg::OFS_PEAK_T:    st_next.rdata = st_reg.peak_t;
        gasr_pkg::OFS_LOW_T:     st_next.rdata = st_reg.low_t;
        gasr_pkg::OFS_AMBIENT:   st_next.rdata = st_reg.ambient;
        gasr_pkg::OFS_HEALTH:    st_next.rdata = st_reg.health;
        gasr_pkg::OFS_USER_LO:   st_next.rdata = USER_WORD[15:0];
        gasr_pkg::OFS_USER_HI:   st_next.rdata = USER_WORD[31:16];
        default:                 st_next.rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.state     <= gasr_pkg::STATE_RESET; // R03 R04
      st_reg.term_rate <= gasr_pkg::TERM_RESET;
      st_reg.low_v     <= gasr_pkg::LOW_V_RESET;
      st_reg.low_t     <= gasr_pkg::LOW_V_RESET;
      st_reg.ambient   <= gasr_pkg::AMB_MIN;
      st_reg.health    <= gasr_pkg::HEALTH_RESET; // R22
      st_reg.pct       <= gasr_pkg::PCT_FULL;
      st_reg.last_pct  <= gasr_pkg::PCT_FULL;
      st_reg.alarm_n   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata               = st_reg.rdata;
  assign relative_charge_pct = st_reg.pct;
  assign alarm_out_n         = st_reg.alarm_n;
endmodule // gasr_regs
`default_nettype wire

//--- dv/gasr_host.sv
// Host model: issues register writes and reads on the command port.
// Assumes rdata is valid just after the read edge.
`timescale 1ns/10ps
`default_nettype none
module gasr_host (
  input wire logic          ref_clk,
  input wire logic [15:0]   rdata,
  output var gasr_pkg::gasr_cmd_t cmd
);
  // Port idle at start
  initial begin
    cmd = '0;
  end
  // One write strobe; writing zero to alarm bits clears them
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    cmd = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1;
    cmd = '0;
  endtask
  // One read strobe, data taken after the read edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    cmd = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    #1;
    cmd = '0;
    d = rdata;
  endtask
endmodule // gasr_host
`default_nettype wire

//--- dv/gasr_regs_chk.sv
// Checker for the gauge register bank.
// Assumes it is bound to gasr_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module gasr_regs_chk (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire gasr_pkg::gasr_cmd_t  cmd,
  input wire logic [15:0]          rdata,
  input wire gasr_pkg::gasr_meas_t meas,
  input wire logic                 minute_tick,
  input wire logic [7:0]           power_mode,
  input wire logic                 cell_therm_en,
  input wire logic                 amb_therm_en,
  input wire logic [15:0]          relative_charge_pct,
  input wire logic                 alarm_out_n
);
  logic [15:0] hv_reg;
  logic [15:0] ht_reg;
  logic        oper;
  // Operational mode flag
  assign oper = (power_mode == gasr_pkg::MODE_OPER);
  // Shadow copies of the high-voltage and high-temperature alarm thresholds written by the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_reg <= 16'h0000;
      ht_reg <= 16'h0000;
    end else if (cmd.wr && cmd.addr == gasr_pkg::OFS_HI_V) begin
      hv_reg <= cmd.wdata;
    end else if (cmd.wr && cmd.addr == gasr_pkg::OFS_HI_T) begin
      ht_reg <= cmd.wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  hi_volt_alarm_a: assert property (
    oper && meas.valid && hv_reg != 16'h0000 && meas.cell_mv > hv_reg |-> ##[1:2] !alarm_out_n)
    else $error("alarm not raised on high voltage");
  hi_temp_alarm_a: assert property (
    oper && cell_therm_en && meas.valid && ht_reg != 16'h0000 && meas.cell_temp > ht_reg
    |-> ##[1:2] !alarm_out_n) else $error("alarm not raised on high temperature");
  sleep_release_a: assert property (
    !oper && $past(power_mode) != gasr_pkg::MODE_OPER |-> alarm_out_n)
    else $error("alarm driven in sleep");
  alarm_oper_a: assert property (
    !alarm_out_n |-> $past(power_mode) == gasr_pkg::MODE_OPER)
    else $error("alarm low without operational mode");
  pct_range_a: assert property (
    relative_charge_pct <= 16'h0064) else $error("percentage above full");
  health_read_a: assert property (
    cmd.rd && cmd.addr == gasr_pkg::OFS_HEALTH |=> rdata <= 16'h0064)
    else $error("health above full");
  ambient_read_a: assert property (
    cmd.rd && cmd.addr == gasr_pkg::OFS_AMBIENT |=> rdata >= 16'h0980 && rdata <= 16'h0dcc)
    else $error("ambient out of range");
  state_reserved_a: assert property (
    cmd.rd && cmd.addr == gasr_pkg::OFS_STATE |=> (rdata & 16'h643f) == 16'h0000)
    else $error("reserved state bit set");
  // Main scenarios reached
  alarm_seen_c: cover property (!alarm_out_n);
  state_clear_c: cover property (cmd.wr && cmd.addr == gasr_pkg::OFS_STATE);
  minute_oper_c: cover property (minute_tick && oper);
endmodule // gasr_regs_chk
bind gasr_regs gasr_regs_chk gasr_regs_chk_inst (.ref_clk, .rst_n, .cmd, .rdata, .meas,
  .minute_tick, .power_mode, .cell_therm_en, .amb_therm_en, .relative_charge_pct, .alarm_out_n);
`default_nettype wire

//--- dv/gasr_regs_bench.sv
// Self-checking bench for the gauge register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module gasr_regs_bench;
  logic                 ref_clk;
  logic                 rst_n;
  gasr_pkg::gasr_cmd_t  cmd;
  gasr_pkg::gasr_meas_t meas;
  logic [15:0]          rdata;
  logic [15:0]          relative_charge_pct;
  logic                 alarm_out_n;
  logic                 minute_tick;
  logic [7:0]           power_mode;
  logic                 cell_therm_en;
  logic                 amb_therm_en;
  int                   fail_count;
  int                   checked;
  int                   cycles;
  // Free-running clock from time zero; inputs are set in the main sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  gasr_regs gasr_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .rdata(rdata),
    .meas(meas), .minute_tick(minute_tick), .power_mode(power_mode),
    .cell_therm_en(cell_therm_en), .amb_therm_en(amb_therm_en),
    .relative_charge_pct(relative_charge_pct), .alarm_out_n(alarm_out_n));
  gasr_host gasr_host_inst (.ref_clk(ref_clk), .rdata(rdata), .cmd(cmd));
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    gasr_host_inst.wr(a, d);
  endtask
  task automatic cr(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    gasr_host_inst.rd(a, d);
    chk(d, e);
  endtask
  // One measurement strobe, then settle
  task automatic smp(input logic [15:0] mv, input logic [15:0] t, input logic [15:0] f,
                     input logic dis);
    @(posedge ref_clk);
    #1;
    meas = '{1'b1, mv, t, 16'h0a00, f, dis, 7'd95};
    @(posedge ref_clk);
    #1;
    meas.valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
    minute_tick = 1'b1;
    @(posedge ref_clk);
    #1;
    minute_tick = 1'b0;
  endtask
  task automatic t_reset();
    cr(8'h19, 16'h00c0);
    cr(8'h1c, 16'h0002);
    cr(8'h32, 16'h0064);
    cr(8'h30, 16'h0980);
    cr(8'h2b, 16'hffff);
    cr(8'h17, 16'h0000);
    cr(8'h18, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_status();
    w(8'h19, 16'h0000);
    cr(8'h19, 16'h0040);
    smp(16'h0e74, 16'h0bb8, 16'h03e8, 1'b0);
    cr(8'h19, 16'h0000);
    chk(relative_charge_pct, 16'h0064);
    cr(8'h30, 16'h0a00);
    cr(8'h32, 16'h005f);
    cr(8'h2b, 16'h0e74);
    cr(8'h2c, 16'h0bb8);
    cr(8'h2d, 16'h0bb8);
    w(8'h2a, 16'h0c00);
    smp(16'h0dac, 16'h0bb8, 16'h03e8, 1'b0);
    cr(8'h2a, 16'h0dac);
    $display("test status done");
  endtask
  task automatic t_level();
    smp(16'h0e74, 16'h0bb8, 16'h0000, 1'b1);
    cr(8'h17, 16'h0001);
    cr(8'h1e, 16'h0000);
    chk(relative_charge_pct, 16'h0000);
    w(8'h1d, 16'h0ce4);
    smp(16'h0c80, 16'h0bb8, 16'h01f4, 1'b1);
    cr(8'h1e, 16'h01f4);
    smp(16'h0c80, 16'h0bb8, 16'h01f4, 1'b1);
    chk(relative_charge_pct, 16'h0000);
    w(8'h1d, 16'h0000);
    w(8'h1e, 16'h0000);
    cr(8'h1e, 16'h0000);
    w(8'h1c, 16'h0004);
    smp(16'h0e74, 16'h0bb8, 16'h03d4, 1'b0);
    chk(relative_charge_pct, 16'h0064);
    w(8'h1c, 16'h0002);
    $display("test level done");
  endtask
  task automatic t_alarm();
    w(8'h1f, 16'h0fa0);
    smp(16'h1004, 16'h0bb8, 16'h03e8, 1'b0);
    chk({15'h0, alarm_out_n}, 16'h0000);
    cr(8'h19, 16'h8000);
    smp(16'h0f3c, 16'h0bb8, 16'h03e8, 1'b0);
    chk({15'h0, alarm_out_n}, 16'h0001);
    cr(8'h19, 16'h8000);
    w(8'h1f, 16'h0000);
    w(8'h19, 16'h0000);
    smp(16'h1004, 16'h0c80, 16'h03e8, 1'b0);
    chk({15'h0, alarm_out_n}, 16'h0001);
    w(8'h21, 16'h0c00);
    smp(16'h0e74, 16'h0c80, 16'h03e8, 1'b0);
    cr(8'h19, 16'h1000);
    cell_therm_en = 1'b0;
    smp(16'h0e74, 16'h0c80, 16'h03e8, 1'b0);
    chk({15'h0, alarm_out_n}, 16'h0001);
    cell_therm_en = 1'b1;
    w(8'h21, 16'h0000);
    w(8'h20, 16'h0b00);
    smp(16'h0e74, 16'h0a00, 16'h03e8, 1'b0);
    chk({15'h0, alarm_out_n}, 16'h0000);
    cr(8'h19, 16'h1100);
    power_mode = 8'h02;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({15'h0, alarm_out_n}, 16'h0001);
    power_mode = 8'h01;
    w(8'h20, 16'h0000);
    w(8'h19, 16'h0000);
    $display("test alarm done");
  endtask
  task automatic t_minute();
    w(8'h24, 16'hfffe);
    w(8'h25, 16'h00ff);
    w(8'h26, 16'h0000);
    w(8'h27, 16'h0000);
    w(8'h28, 16'h0000);
    w(8'h29, 16'h0000);
    smp(16'h0e74, 16'h0bb8, 16'h03e8, 1'b0);
    tick();
    tick();
    cr(8'h24, 16'hffff);
    cr(8'h25, 16'h00ff);
    cr(8'h26, 16'h1770);
    cr(8'h28, 16'h00c8);
    power_mode = 8'h02;
    tick();
    cr(8'h26, 16'h1770);
    cr(8'h28, 16'h00c8);
    power_mode = 8'h01;
    w(8'h26, 16'hfff0);
    w(8'h27, 16'h0fff);
    w(8'h28, 16'hffa0);
    w(8'h29, 16'hffff);
    tick();
    cr(8'h26, 16'hffff);
    cr(8'h27, 16'h0fff);
    cr(8'h28, 16'hffff);
    $display("test minute done");
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    fail_count = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    minute_tick = 1'b0;
    power_mode = 8'h01;
    cell_therm_en = 1'b1;
    amb_therm_en = 1'b1;
    meas = '{1'b0, 16'h0e74, 16'h0bb8, 16'h0a00, 16'h03e8, 1'b1, 7'd95};
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_status();
    t_level();
    t_alarm();
    t_minute();
    summarize();
  end
endmodule // gasr_regs_bench
`default_nettype wire
